//--- logic/fnnd_pkg.sv
// shared constants for the negate and sync no-op decoder
package fnnd_pkg;
	localparam int FNND_W_FMT = 3;
	localparam int FNND_W_OPM = 7;
	localparam int FNND_W_CPID = 3;
	localparam int FNND_W_XFLG = 8;
	// operation word fields
	localparam int FNND_OP_CPID_HI = 11;
	localparam int FNND_OP_CPID_LO = 9;
	localparam int FNND_OP_TYPE_HI = 8;
	localparam int FNND_OP_TYPE_LO = 6;
	localparam int FNND_OP_MODE_HI = 5;
	localparam int FNND_OP_MODE_LO = 3;
	localparam int FNND_OP_REG_HI = 2;
	localparam int FNND_OP_REG_LO = 0;
	localparam logic [3:0] FNND_OP_LINE = 4'hf;
	localparam logic [2:0] FNND_TYPE_GEN = 3'h0;
	localparam logic [8:0] FNND_NOOP_LOW = 9'h080;
	localparam logic [15:0] FNND_NOOP_EXT = 16'h0000;
	// extension word fields
	localparam int FNND_EX_RM = 14;
	localparam int FNND_EX_SRC_HI = 12;
	localparam int FNND_EX_SRC_LO = 10;
	localparam int FNND_EX_DST_HI = 9;
	localparam int FNND_EX_DST_LO = 7;
	localparam int FNND_EX_OPM_HI = 6;
	localparam int FNND_EX_OPM_LO = 0;
	// opmodes
	localparam logic [6:0] FNND_OPM_NEG = 7'h1a;
	localparam logic [6:0] FNND_OPM_NEG_S = 7'h5a;
	localparam logic [6:0] FNND_OPM_NEG_D = 7'h5e;
	// source formats
	localparam logic [2:0] FNND_FMT_LONG = 3'h0;
	localparam logic [2:0] FNND_FMT_SGL = 3'h1;
	localparam logic [2:0] FNND_FMT_EXT = 3'h2;
	localparam logic [2:0] FNND_FMT_PACK = 3'h3;
	localparam logic [2:0] FNND_FMT_WORD = 3'h4;
	localparam logic [2:0] FNND_FMT_DBL = 3'h5;
	localparam logic [2:0] FNND_FMT_BYTE = 3'h6;
	// effective address modes
	localparam logic [2:0] FNND_EA_DREG = 3'h0;
	localparam logic [2:0] FNND_EA_AREG = 3'h1;
	localparam logic [2:0] FNND_EA_IND = 3'h2;
	localparam logic [2:0] FNND_EA_POST = 3'h3;
	localparam logic [2:0] FNND_EA_PRE = 3'h4;
	localparam logic [2:0] FNND_EA_DISP = 3'h5;
	localparam logic [2:0] FNND_EA_IDX = 3'h6;
	localparam logic [2:0] FNND_EA_EXT = 3'h7;
	localparam logic [2:0] FNND_EXR_ABSW = 3'h0;
	localparam logic [2:0] FNND_EXR_ABSL = 3'h1;
	localparam logic [2:0] FNND_EXR_PCD = 3'h2;
	localparam logic [2:0] FNND_EXR_PCX = 3'h3;
	localparam logic [2:0] FNND_EXR_IMM = 3'h4;
	// rounding precision selection
	localparam logic [1:0] FNND_RND_CTRL = 2'h0;
	localparam logic [1:0] FNND_RND_SGL = 2'h1;
	localparam logic [1:0] FNND_RND_DBL = 2'h2;
	// exception byte bit positions
	localparam int FNND_XB_BRANCH_UNORDERED_FLAG = 7;
	localparam int FNND_XB_SIGNALING_NAN_FLAG = 6;
	localparam int FNND_XB_OPERAND_ERROR_FLAG = 5;
	localparam int FNND_XB_OVERFLOW_FLAG = 4;
	localparam int FNND_XB_UNDERFLOW_FLAG = 3;
	localparam int FNND_XB_DZ = 2;
	localparam int FNND_XB_RESULT_INEXACT_FLAG = 1;
	localparam int FNND_XB_INPUT_INEXACT_FLAG = 0;
	localparam logic [7:0] FNND_XFLG_RST = 8'h00;
	localparam logic [2:0] FNND_CPID_DEF = 3'h1;
	localparam int FNND_NEG_LAT = 3;
	typedef enum logic [1:0] {
		FNND_ACC_DATA,
		FNND_ACC_NONE,
		FNND_ACC_BADEA,
		FNND_ACC_BADFMT
	} fnnd_acc_t;
endpackage

//--- logic/fnnd_ea_check.sv
// source addressing and format legality check
`timescale 1ns/100ps
module fnnd_ea_check
	import fnnd_pkg::*;
(
	input  wire logic                  i_rm,
	input  wire logic [2:0]            i_mode,
	input  wire logic [2:0]            i_reg,
	input  wire logic [FNND_W_FMT-1:0] i_fmt,
	output fnnd_acc_t                  o_acc
);
	import fnnd_pkg::*;

	function automatic logic fmt_fits_dreg(input logic [2:0] f);
		return f == FNND_FMT_BYTE || f == FNND_FMT_WORD
			|| f == FNND_FMT_LONG || f == FNND_FMT_SGL;
	endfunction

	function automatic logic fmt_known(input logic [2:0] f);
		return f != 3'h7;
	endfunction

	always_comb begin
		o_acc = FNND_ACC_DATA;
		if (!i_rm) begin
			o_acc = FNND_ACC_NONE;
		end else if (!fmt_known(i_fmt)) begin
			o_acc = FNND_ACC_BADFMT;
		end else begin
			case (i_mode)
				FNND_EA_DREG: begin
					if (!fmt_fits_dreg(i_fmt)) begin
						o_acc = FNND_ACC_BADEA;
					end
				end
				FNND_EA_AREG: o_acc = FNND_ACC_BADEA;
				FNND_EA_IND, FNND_EA_POST, FNND_EA_PRE,
				FNND_EA_DISP, FNND_EA_IDX: o_acc = FNND_ACC_DATA;
				FNND_EA_EXT: begin
					case (i_reg)
						FNND_EXR_ABSW, FNND_EXR_ABSL, FNND_EXR_PCD,
						FNND_EXR_PCX, FNND_EXR_IMM: o_acc = FNND_ACC_DATA;
						default: o_acc = FNND_ACC_BADEA;
					endcase
				end
				default: o_acc = FNND_ACC_BADEA;
			endcase
		end
	end
endmodule

//--- logic/fnnd_decoder.sv
// negate and sync no-op decode with concurrency control
// What this block does
// - ea field names source only when operand-source bit is one
// - only data addressing modes accepted; address register direct refused
// - data register direct only for byte, word, long or single
// - source bit zero means register to register, one means memory
// - register form: source field names source fp data register
// - memory form: source field is the data format code
// - packed decimal format raises unimplemented data type exception
// - result to destination register; equal fields share one register
// - three opmodes select negate rounding: control, single, double
// - underflow only for extended denormal source; other listed flags clear
// - input inexact only for packed source, else cleared
// - no-op does nothing and leaves status unchanged
// - integer unit released once operands are taken
// - no-op holds integer unit until prior instructions finish
// - no-op takes pending exception as preinstruction exception
// - new instruction may overlap; no-op waits for both
// - operand taken always releases host, exception not reported then
// - pending exception reported when next instruction starts
// - negate converts to extended, inverts sign, stores to destination
// - no-op shares encoding with zero displacement false branch
// - coprocessor id field selects which coprocessor executes
`timescale 1ns/100ps
module fnnd_decoder
	import fnnd_pkg::*;
#(
	parameter logic [FNND_W_CPID-1:0] MY_CPID = FNND_CPID_DEF,
	parameter int                     NEG_LAT = FNND_NEG_LAT
) (
	input  wire logic                    i_clk,
	input  wire logic                    i_reset,
	input  wire logic                    i_issue,
	input  wire logic [15:0]             i_op_word,
	input  wire logic [15:0]             i_ext_word,
	input  wire logic                    i_operand_valid,
	input  wire logic                    i_src_ext_denorm,
	input  wire logic                    i_src_pack_inexact,
	input  wire logic                    i_src_signaling_nan_flag,
	input  wire logic                    i_src_is_nan,
	output logic                         o_accept,
	output logic                         o_release,
	output logic                         o_busy,
	output logic                         o_pre_exception,
	output logic                         o_illegal,
	output logic                         o_unimpl_type,
	output logic                         o_fetch_ea,
	output logic [2:0]                   o_ea_mode,
	output logic [2:0]                   o_ea_reg,
	output logic [FNND_W_FMT-1:0]        o_src_fmt,
	output logic                         o_src_is_reg,
	output logic [2:0]                   o_src_fpreg,
	output logic                         o_negate_go,
	output logic [2:0]                   o_dst_fpreg,
	output logic [1:0]                   o_round_sel,
	output logic                         o_convert_ext,
	output logic                         o_invert_sign,
	output logic                         o_result_write,
	output logic [FNND_W_XFLG-1:0]       o_exc_byte,
	output logic                         o_exc_update
);
	import fnnd_pkg::*;

	localparam int CW = $clog2(NEG_LAT + 1);

	typedef enum logic [1:0] {
		FNND_IDLE,
		FNND_WAIT_OPND,
		FNND_NOOP_HOLD
	} fnnd_state_t;

	function automatic logic is_negate(input logic [6:0] opm);
		return opm == FNND_OPM_NEG || opm == FNND_OPM_NEG_S
			|| opm == FNND_OPM_NEG_D;
	endfunction

	// decode of the presented words
	logic       w_line_ok;
	logic       w_rm;
	logic [2:0] w_src;
	logic [2:0] w_dst;
	logic [6:0] w_opm;
	logic       w_is_noop;
	logic       w_is_neg;
	fnnd_acc_t  w_acc;

	assign w_line_ok = i_op_word[15:12] == FNND_OP_LINE
		&& i_op_word[FNND_OP_CPID_HI:FNND_OP_CPID_LO] == MY_CPID;
	assign w_rm  = i_ext_word[FNND_EX_RM];
	assign w_src = i_ext_word[FNND_EX_SRC_HI:FNND_EX_SRC_LO];
	assign w_dst = i_ext_word[FNND_EX_DST_HI:FNND_EX_DST_LO];
	assign w_opm = i_ext_word[FNND_EX_OPM_HI:FNND_EX_OPM_LO];
	assign w_is_noop = w_line_ok
		&& i_op_word[FNND_OP_TYPE_HI:0] == FNND_NOOP_LOW
		&& i_ext_word == FNND_NOOP_EXT;
	assign w_is_neg = w_line_ok
		&& i_op_word[FNND_OP_TYPE_HI:FNND_OP_TYPE_LO] == FNND_TYPE_GEN
		&& i_ext_word[15] == 1'b0 && i_ext_word[13] == 1'b0
		&& is_negate(w_opm);

	fnnd_ea_check u_ea (
		.i_rm   (w_rm),
		.i_mode (i_op_word[FNND_OP_MODE_HI:FNND_OP_MODE_LO]),
		.i_reg  (i_op_word[FNND_OP_REG_HI:FNND_OP_REG_LO]),
		.i_fmt  (w_src),
		.o_acc  (w_acc)
	);

	// state
	fnnd_state_t state_r, state_nxt;
	logic [CW-1:0] exec0_r, exec0_nxt;
	logic [CW-1:0] exec1_r, exec1_nxt;
	logic          pend_r, pend_nxt;
	logic          rm_r, rm_nxt;
	logic [2:0]    fmt_r, fmt_nxt;
	logic [2:0]    dst_r, dst_nxt;
	logic [1:0]    rnd_r, rnd_nxt;
	logic          go_r, go_nxt;
	logic          ill_r, ill_nxt;
	logic          unimp_r, unimp_nxt;
	logic          pre_r, pre_nxt;
	logic          wr_r, wr_nxt;
	logic [7:0]    xb_r, xb_nxt;
	logic          xup_r, xup_nxt;
	logic          w_start_neg;
	logic          w_done0;
	logic          w_done1;
	logic [7:0]    w_xb;

	assign w_done0 = exec0_r == CW'(1);
	assign w_done1 = exec1_r == CW'(1);

	always_comb begin
		w_xb = FNND_XFLG_RST;
		w_xb[FNND_XB_SIGNALING_NAN_FLAG] = i_src_signaling_nan_flag;
		w_xb[FNND_XB_UNDERFLOW_FLAG] = i_src_ext_denorm;
		w_xb[FNND_XB_INPUT_INEXACT_FLAG] = rm_r && fmt_r == FNND_FMT_PACK
			&& i_src_pack_inexact;
	end

	always_comb begin
		state_nxt = state_r;
		exec0_nxt = exec0_r;
		exec1_nxt = exec1_r;
		pend_nxt  = pend_r;
		rm_nxt    = rm_r;
		fmt_nxt   = fmt_r;
		dst_nxt   = dst_r;
		rnd_nxt   = rnd_r;
		go_nxt    = 1'b0;
		ill_nxt   = 1'b0;
		unimp_nxt = 1'b0;
		pre_nxt   = 1'b0;
		wr_nxt    = 1'b0;
		xb_nxt    = xb_r;
		xup_nxt   = 1'b0;
		o_accept  = 1'b0;
		o_release = 1'b0;
		w_start_neg = 1'b0;
		if (exec0_r != '0) begin
			exec0_nxt = exec0_r - CW'(1);
		end
		if (exec1_r != '0) begin
			exec1_nxt = exec1_r - CW'(1);
		end
		if (w_done0 || w_done1) begin
			wr_nxt  = 1'b1;
			xb_nxt  = w_xb;
			xup_nxt = 1'b1;
		end
		case (state_r)
			FNND_IDLE: begin
				if (i_issue && w_line_ok) begin
					o_accept = 1'b1;
					if (pend_r && (w_is_neg || w_is_noop)) begin
						pre_nxt  = 1'b1;
						pend_nxt = 1'b0;
					end else if (w_is_noop) begin
						state_nxt = FNND_NOOP_HOLD;
					end else if (!w_is_neg || w_acc == FNND_ACC_BADEA
							|| w_acc == FNND_ACC_BADFMT) begin
						ill_nxt = 1'b1;
					end else if (w_rm && w_src == FNND_FMT_PACK) begin
						unimp_nxt = 1'b1;
					end else begin
						rm_nxt  = w_rm;
						fmt_nxt = w_src;
						dst_nxt = w_dst;
						rnd_nxt = w_opm == FNND_OPM_NEG_S ? FNND_RND_SGL
							: w_opm == FNND_OPM_NEG_D ? FNND_RND_DBL
							: FNND_RND_CTRL;
						state_nxt = FNND_WAIT_OPND;
					end
				end
			end
			FNND_WAIT_OPND: begin
				if (i_operand_valid && (exec0_r == '0 || exec1_r == '0)) begin
					o_release   = 1'b1;
					w_start_neg = 1'b1;
					state_nxt   = FNND_IDLE;
					if (exec0_r == '0) begin
						exec0_nxt = CW'(NEG_LAT);
					end else begin
						exec1_nxt = CW'(NEG_LAT);
					end
				end
			end
			FNND_NOOP_HOLD: begin
				if (exec0_r == '0 && exec1_r == '0) begin
					o_release = 1'b1;
					state_nxt = FNND_IDLE;
					if (pend_r) begin
						pre_nxt  = 1'b1;
						pend_nxt = 1'b0;
					end
				end
			end
			default: state_nxt = FNND_IDLE;
		endcase
		go_nxt = w_start_neg;
		// exception kept pending; a new one beats a clear
		if ((w_done0 || w_done1) && w_xb != FNND_XFLG_RST) begin
			pend_nxt = 1'b1;
		end
		if (i_reset) begin
			state_nxt = FNND_IDLE;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_r <= FNND_IDLE;
			exec0_r <= '0;
			exec1_r <= '0;
			pend_r  <= 1'b0;
			rm_r    <= 1'b0;
			fmt_r   <= FNND_FMT_EXT;
			dst_r   <= 3'h0;
			rnd_r   <= FNND_RND_CTRL;
			go_r    <= 1'b0;
			ill_r   <= 1'b0;
			unimp_r <= 1'b0;
			pre_r   <= 1'b0;
			wr_r    <= 1'b0;
			xb_r    <= FNND_XFLG_RST;
			xup_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			exec0_r <= exec0_nxt;
			exec1_r <= exec1_nxt;
			pend_r  <= pend_nxt;
			rm_r    <= rm_nxt;
			fmt_r   <= fmt_nxt;
			dst_r   <= dst_nxt;
			rnd_r   <= rnd_nxt;
			go_r    <= go_nxt;
			ill_r   <= ill_nxt;
			unimp_r <= unimp_nxt;
			pre_r   <= pre_nxt;
			wr_r    <= wr_nxt;
			xb_r    <= xb_nxt;
			xup_r   <= xup_nxt;
		end
	end

	assign o_src_fpreg     = rm_r ? 3'h0 : fmt_r;
	assign o_src_is_reg    = !rm_r;
	assign o_src_fmt       = rm_r ? fmt_r : FNND_FMT_EXT;
	assign o_fetch_ea      = state_r == FNND_WAIT_OPND && rm_r;
	assign o_ea_mode       = i_op_word[FNND_OP_MODE_HI:FNND_OP_MODE_LO];
	assign o_ea_reg        = i_op_word[FNND_OP_REG_HI:FNND_OP_REG_LO];
	assign o_busy          = state_r != FNND_IDLE;
	assign o_pre_exception = pre_r;
	assign o_illegal       = ill_r;
	assign o_unimpl_type   = unimp_r;
	assign o_negate_go     = go_r;
	assign o_dst_fpreg     = dst_r;
	assign o_round_sel     = rnd_r;
	assign o_convert_ext   = go_r && rm_r && fmt_r != FNND_FMT_EXT;
	assign o_invert_sign   = go_r;
	assign o_result_write  = wr_r;
	assign o_exc_byte      = xb_r;
	assign o_exc_update    = xup_r;

	a_noop_waits_done: assert property (@(posedge i_clk) disable iff (i_reset)
		(state_r == FNND_NOOP_HOLD && o_release) |-> exec0_r == '0
		&& exec1_r == '0) else $error("noop released early");
	a_neg_release_go: assert property (@(posedge i_clk) disable iff (i_reset)
		(state_r == FNND_WAIT_OPND && o_release) |=> o_negate_go)
		else $error("negate not started after release");
	a_write_after_lat: assert property (@(posedge i_clk) disable iff (i_reset)
		o_negate_go |-> ##(NEG_LAT) o_result_write)
		else $error("result write not at latency");
	a_exc_clears: assert property (@(posedge i_clk) disable iff (i_reset)
		o_exc_update |-> (o_exc_byte[FNND_XB_BRANCH_UNORDERED_FLAG] == 1'b0
		&& o_exc_byte[FNND_XB_OPERAND_ERROR_FLAG] == 1'b0
		&& o_exc_byte[FNND_XB_OVERFLOW_FLAG] == 1'b0
		&& o_exc_byte[FNND_XB_DZ] == 1'b0
		&& o_exc_byte[FNND_XB_RESULT_INEXACT_FLAG] == 1'b0))
		else $error("negate set a cleared flag");
	a_noop_keeps_stat: assert property (@(posedge i_clk) disable iff (i_reset)
		(state_r == FNND_NOOP_HOLD && !o_result_write) |=>
		$stable(o_exc_byte) || o_result_write)
		else $error("noop changed status");
	a_packed_unimpl: assert property (@(posedge i_clk) disable iff (i_reset)
		(o_accept && w_is_neg && !pend_r && w_rm && w_src == FNND_FMT_PACK
		&& w_acc == FNND_ACC_DATA) |=> o_unimpl_type && !o_busy)
		else $error("packed format not trapped");
	a_areg_refused: assert property (@(posedge i_clk) disable iff (i_reset)
		(o_accept && w_is_neg && !pend_r && w_rm
		&& i_op_word[FNND_OP_MODE_HI:FNND_OP_MODE_LO] == FNND_EA_AREG)
		|=> o_illegal) else $error("address reg direct accepted");
	a_pend_reported: assert property (@(posedge i_clk) disable iff (i_reset)
		(o_accept && pend_r && w_is_noop) |=> o_pre_exception
		&& (!pend_r || o_result_write))
		else $error("pending exception not reported");
	a_rnd_select: assert property (@(posedge i_clk) disable iff (i_reset)
		(o_accept && w_is_neg && !pend_r && !w_rm && w_opm == FNND_OPM_NEG_D)
		|=> o_round_sel == FNND_RND_DBL && o_dst_fpreg == $past(w_dst))
		else $error("double rounding not selected");
endmodule

//--- test/fnnd_host_model.sv
// host side model: supplies the source operand after a set delay
`timescale 1ns/100ps
module fnnd_host_model (
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire logic       i_busy,
	input  wire logic       i_release,
	input  wire logic [3:0] i_dly,
	output logic            o_operand_valid
);
	logic [3:0] wait_r;
	logic [3:0] wait_nxt;

	always_comb begin
		wait_nxt = wait_r;
		if (!i_busy || i_release) begin
			wait_nxt = 4'h0;
		end else if (wait_r != 4'hf) begin
			wait_nxt = wait_r + 4'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wait_r <= 4'h0;
		end else begin
			wait_r <= wait_nxt;
		end
	end

	assign o_operand_valid = i_busy && (wait_r >= i_dly);
endmodule

//--- test/fnnd_decoder_tb.sv
// self-checking bench for the negate and sync no-op decoder
`timescale 1ns/100ps
module fnnd_decoder_tb;
	import fnnd_pkg::*;
	localparam int LAT = 3;
	logic       i_clk, i_reset, i_issue, i_operand_valid, i_src_ext_denorm;
	logic       i_src_pack_inexact, i_src_signaling_nan_flag, o_fetch_ea, o_exc_update;
	logic [2:0] o_ea_mode, o_ea_reg;
	logic [15:0] i_op_word, i_ext_word;
	logic       o_accept, o_release, o_busy, o_pre_exception, o_illegal;
	logic       o_unimpl_type, o_src_is_reg, o_negate_go, o_convert_ext;
	logic       o_invert_sign, o_result_write;
	logic [2:0] o_src_fmt, o_src_fpreg, o_dst_fpreg;
	logic [1:0] o_round_sel;
	logic [7:0] o_exc_byte;
	logic [3:0] dly;
	logic       seen;
	int         n_fail, cmp_count, i;
	logic [6:0] opm [3] = '{FNND_OPM_NEG, FNND_OPM_NEG_S, FNND_OPM_NEG_D};
	logic [9:0] eat [17] = '{10'h083, 10'h02b, 10'h020, 10'h022, 10'h028,
		10'h02c, 10'h025, 10'h384, 10'h394, 10'h3a4, 10'h3b4, 10'h3c4,
		10'h3d5, 10'h284, 10'h304, 10'h204, 10'h184};

	fnnd_decoder #(.NEG_LAT(LAT)) fnnd_decoder_inst (
		.i_clk(i_clk), .i_reset(i_reset), .i_issue(i_issue),
		.i_op_word(i_op_word), .i_ext_word(i_ext_word),
		.i_operand_valid(i_operand_valid),
		.i_src_ext_denorm(i_src_ext_denorm),
		.i_src_pack_inexact(i_src_pack_inexact),
		.i_src_signaling_nan_flag(i_src_signaling_nan_flag), .i_src_is_nan(1'b0),
		.o_accept(o_accept), .o_release(o_release), .o_busy(o_busy),
		.o_pre_exception(o_pre_exception), .o_illegal(o_illegal),
		.o_unimpl_type(o_unimpl_type), .o_fetch_ea(o_fetch_ea),
		.o_ea_mode(o_ea_mode), .o_ea_reg(o_ea_reg),
		.o_src_fmt(o_src_fmt), .o_src_is_reg(o_src_is_reg),
		.o_src_fpreg(o_src_fpreg), .o_negate_go(o_negate_go),
		.o_dst_fpreg(o_dst_fpreg), .o_round_sel(o_round_sel),
		.o_convert_ext(o_convert_ext), .o_invert_sign(o_invert_sign),
		.o_result_write(o_result_write), .o_exc_byte(o_exc_byte),
		.o_exc_update(o_exc_update)
	);

	fnnd_host_model fnnd_host_model_inst (
		.i_clk(i_clk), .i_reset(i_reset), .i_busy(o_busy),
		.i_release(o_release), .i_dly(dly),
		.o_operand_valid(i_operand_valid)
	);

	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	task close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task tick;
		@(negedge i_clk);
		i_issue = 1'b0;
		#1;
		seen = seen | o_result_write;
	endtask

	task issue(input logic [15:0] op, input logic [15:0] ext,
		input logic acc);
		@(negedge i_clk);
		i_issue = 1'b1;
		i_op_word = op;
		i_ext_word = ext;
		#1;
		chk(16'(o_accept), 16'(acc));
	endtask

	// 0 release, 1 idle, 2 pending exception taken
	task automatic wait_on(input int w);
		int k;
		logic hit;
		for (k = 0; k < 60; k++) begin
			hit = (w == 0) ? o_release : (w == 1) ? !o_busy : o_pre_exception;
			if (hit === 1'b1) break;
			tick;
		end
		if (k == 60) begin
			n_fail++;
			$display("[FAIL] %0t wait %0d got %h exp %h", $time, w, 1'b0, 1'b1);
			close_out;
		end
	endtask

	task run_neg(input logic cvt, input logic [7:0] exc);
		wait_on(0);
		tick;
		chk(16'(o_negate_go), 16'h1);
		chk(16'(o_invert_sign), 16'h1);
		chk(16'(o_convert_ext), 16'(cvt));
		repeat (LAT) tick;
		chk(16'(o_result_write), 16'h1);
		chk(16'(o_exc_update), 16'h1);
		chk(16'(o_exc_byte), 16'(exc));
	endtask

	initial begin
		i_reset = 1'b1;
		i_issue = 1'b0;
		i_op_word = 16'h0000;
		i_ext_word = 16'h0000;
		i_src_ext_denorm = 1'b0;
		i_src_pack_inexact = 1'b0;
		i_src_signaling_nan_flag = 1'b0;
		dly = 4'h0;
		seen = 1'b0;
		n_fail = 0;
		cmp_count = 0;
		repeat (3) @(negedge i_clk);
		i_reset = 1'b0;
		#1;
		chk(16'(o_busy), 16'h0);
		chk(16'(o_exc_byte), 16'h0);
		$display("test 0 done");
		// register form, all three rounding opmodes, one with equal fields
		for (i = 0; i < 3; i++) begin
			issue(16'hf200, {3'b000, 3'(i + 3), 3'(5 - i), opm[i]}, 1'b1);
			tick;
			chk(16'(o_round_sel), 16'(i));
			chk(16'(o_dst_fpreg), 16'(5 - i));
			chk(16'(o_src_is_reg), 16'h1);
			chk(16'(o_src_fpreg), 16'(i + 3));
			chk(16'(o_fetch_ea), 16'h0);
			run_neg(1'b0, 8'h00);
		end
		$display("test 1 done");
		// memory form, every format code; input inexact must stay clear
		i_src_pack_inexact = 1'b1;
		for (i = 0; i < 7; i++) begin
			issue({10'h3c8, 6'o23}, {3'b010, 3'(i), 3'h1, FNND_OPM_NEG}, 1'b1);
			tick;
			if (i == 3) begin
				chk(16'(o_unimpl_type), 16'h1);
				wait_on(1);
			end else begin
				chk(16'(o_illegal), 16'h0);
				chk(16'(o_src_fmt), 16'(i));
				chk(16'(o_src_is_reg), 16'h0);
				chk(16'(o_fetch_ea), 16'h1);
				chk(16'(o_ea_mode), 16'h2);
				chk(16'(o_ea_reg), 16'h3);
				run_neg(i != 2, 8'h00);
			end
		end
		i_src_pack_inexact = 1'b0;
		$display("test 2 done");
		// addressing modes and data register format limits
		for (i = 0; i < 17; i++) begin
			issue({10'h3c8, eat[i][9:4]},
				{3'b010, eat[i][3:1], 3'h0, FNND_OPM_NEG}, 1'b1);
			tick;
			chk(16'(o_illegal), 16'(eat[i][0]));
			wait_on(1);
		end
		$display("test 3 done");
		// foreign opmode, foreign coprocessor id, issue while busy
		issue(16'hf200, {3'b000, 3'h1, 3'h1, 7'h23}, 1'b1);
		tick;
		chk(16'(o_illegal), 16'h1);
		wait_on(1);
		issue(16'hf400, {3'b000, 3'h1, 3'h1, FNND_OPM_NEG}, 1'b0);
		tick;
		chk(16'(o_busy), 16'h0);
		dly = 4'h4;
		issue(16'hf200, {3'b000, 3'h1, 3'h2, FNND_OPM_NEG}, 1'b1);
		tick;
		issue(16'hf200, {3'b000, 3'h1, 3'h2, FNND_OPM_NEG}, 1'b0);
		wait_on(1);
		dly = 4'h0;
		$display("test 4 done");
		// no-op right behind a negate must wait for its completion
		issue(16'hf200, {3'b000, 3'h6, 3'h7, FNND_OPM_NEG_D}, 1'b1);
		tick;
		wait_on(0);
		seen = 1'b0;
		issue(16'hf280, 16'h0000, 1'b1);
		tick;
		wait_on(0);
		chk(16'(seen), 16'h1);
		chk(16'(o_exc_byte), 16'h00);
		wait_on(1);
		$display("test 5 done");
		// extended denormal source leaves a pending exception
		i_src_ext_denorm = 1'b1;
		issue({10'h3c8, 6'o23}, {3'b010, FNND_FMT_EXT, 3'h2, FNND_OPM_NEG}, 1'b1);
		tick;
		run_neg(1'b0, 8'h08);
		i_src_ext_denorm = 1'b0;
		wait_on(1);
		issue(16'hf280, 16'h0000, 1'b1);
		tick;
		wait_on(2);
		wait_on(1);
		i_src_ext_denorm = 1'b1;
		i_src_signaling_nan_flag = 1'b1;
		issue({10'h3c8, 6'o23}, {3'b010, FNND_FMT_EXT, 3'h2, FNND_OPM_NEG}, 1'b1);
		tick;
		run_neg(1'b0, 8'h48);
		i_src_ext_denorm = 1'b0;
		i_src_signaling_nan_flag = 1'b0;
		wait_on(1);
		issue(16'hf200, {3'b000, 3'h1, 3'h1, FNND_OPM_NEG}, 1'b1);
		tick;
		chk(16'(o_pre_exception), 16'h1);
		wait_on(1);
		$display("test 6 done");
		// reset in mid-run while a negate waits for its operand
		dly = 4'h4;
		issue(16'hf200, {3'b000, 3'h1, 3'h3, FNND_OPM_NEG}, 1'b1);
		tick;
		i_reset = 1'b1;
		tick;
		i_reset = 1'b0;
		dly = 4'h0;
		chk(16'(o_busy), 16'h0);
		chk(16'(o_exc_byte), 16'h00);
		issue(16'hf200, {3'b000, 3'h1, 3'h3, FNND_OPM_NEG}, 1'b1);
		tick;
		chk(16'(o_dst_fpreg), 16'h3);
		run_neg(1'b0, 8'h00);
		$display("test 7 done");
		close_out;
	end
endmodule
